// *** core/active_energy_accumulator.sv ***
/*
  Active energy accumulator: two-stage signed integration of per-phase total
  and fundamental active power into watt-hour registers, with half-full and
  line-cycle status, interrupt output, read-with-reset and phase B voltage
  selection.
  Assumes power words, voltages, zero-crossing pulses and the host port all
  come from logic on mclk_i.
*/
`timescale 1ns/1ps
module active_energy_accumulator #(
  parameter int POWER_W = energy_acc_pkg::POWER_W,
  parameter int VOLT_W = energy_acc_pkg::VOLT_W
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire energy_acc_pkg::reg_req_t req_i,
  input wire logic [2:0][POWER_W-1:0] total_power_i,
  input wire logic [2:0][POWER_W-1:0] fund_power_i,
  input wire logic [VOLT_W-1:0] volt_a_i,
  input wire logic [VOLT_W-1:0] volt_b_i,
  input wire logic [VOLT_W-1:0] volt_c_i,
  input wire logic [2:0] zero_cross_i,
  output logic [energy_acc_pkg::DATA_W-1:0] rdata_o,
  output logic irq_out_n_o,
  output logic sample_tick_o,
  output logic [energy_acc_pkg::CHANNELS-1:0] energy_pulse_o,
  output logic [energy_acc_pkg::CHANNELS-1:0] phase_sign_o,
  output logic [VOLT_W:0] phase_b_voltage_o,
  output logic [1:0] pulse_output_sign_mode_o
);

  localparam int CH = energy_acc_pkg::CHANNELS;
  localparam int WH_W = energy_acc_pkg::WH_W;
  localparam int DW = energy_acc_pkg::DATA_W;
  localparam int TPW = energy_acc_pkg::THR_PART_W;
  localparam int DIV_W = $clog2(energy_acc_pkg::SAMPLE_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(energy_acc_pkg::SAMPLE_CYCLES - 1);

  // Maps an energy register address to its channel, or flags a miss.
  function automatic logic [3:0] energy_index(input logic [energy_acc_pkg::ADDR_W-1:0] a);
    logic [energy_acc_pkg::ADDR_W-1:0] off;
    off = a - energy_acc_pkg::ADDR_ENERGY_BASE;
    if (a >= energy_acc_pkg::ADDR_ENERGY_BASE && off < 4'(CH)) begin
      energy_index = {1'b1, off[2:0]};
    end else begin
      energy_index = 4'h0;
    end
  endfunction : energy_index

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [TPW-1:0] thr_high_reg;
  logic [TPW-1:0] thr_low_reg;
  logic [DW-1:0] mask_reg;
  logic [DW-1:0] line_mode_reg;
  logic [DW-1:0] acc_mode_reg;
  logic [15:0] half_cycles_reg;
  logic line_en;
  logic read_clear_en;
  logic half_cycles_wr;

  assign line_en = line_mode_reg[energy_acc_pkg::LCM_ENERGY_EN];
  assign read_clear_en = line_mode_reg[energy_acc_pkg::LCM_READ_CLEAR];
  assign half_cycles_wr = req_i.wr && req_i.addr == energy_acc_pkg::ADDR_HALF_CYCLES;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      thr_high_reg <= energy_acc_pkg::THR_PART_RESET;
      thr_low_reg <= energy_acc_pkg::THR_PART_RESET;
      mask_reg <= energy_acc_pkg::MASK_RESET;
      line_mode_reg <= energy_acc_pkg::LINE_MODE_RESET;
      acc_mode_reg <= energy_acc_pkg::ACC_MODE_RESET;
      half_cycles_reg <= energy_acc_pkg::HALF_CYCLES_RESET;
    end else if (req_i.wr) begin
      case (req_i.addr)
        energy_acc_pkg::ADDR_THR_HIGH: thr_high_reg <= req_i.wdata[TPW-1:0];
        energy_acc_pkg::ADDR_THR_LOW: thr_low_reg <= req_i.wdata[TPW-1:0];
        energy_acc_pkg::ADDR_MASK: mask_reg <= req_i.wdata & energy_acc_pkg::STATUS_BITS;
        energy_acc_pkg::ADDR_LINE_MODE: begin
          line_mode_reg <= req_i.wdata & energy_acc_pkg::LINE_MODE_BITS;
        end
        energy_acc_pkg::ADDR_ACC_MODE: begin
          acc_mode_reg <= req_i.wdata & energy_acc_pkg::ACC_MODE_BITS;
        end
        energy_acc_pkg::ADDR_HALF_CYCLES: half_cycles_reg <= req_i.wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pulse_output_sign_mode_o <= 2'b00;
    end else begin
      pulse_output_sign_mode_o <= acc_mode_reg[energy_acc_pkg::ACM_SIGN_MODE_LO +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample strobe

  logic [DIV_W-1:0] div_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      div_reg <= '0;
      sample_tick_o <= 1'b0;
    end else begin
      sample_tick_o <= div_reg == DIV_LAST;
      div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase B voltage selection

  logic signed [VOLT_W:0] va_ext;
  logic signed [VOLT_W:0] vb_ext;
  logic signed [VOLT_W:0] vc_ext;
  logic [VOLT_W:0] vb_sel;
  energy_acc_pkg::phase_b_sel_t b_sel;

  always_comb begin
    va_ext = $signed({volt_a_i[VOLT_W-1], volt_a_i});
    vb_ext = $signed({volt_b_i[VOLT_W-1], volt_b_i});
    vc_ext = $signed({volt_c_i[VOLT_W-1], volt_c_i});
    b_sel = energy_acc_pkg::phase_b_sel_t'(acc_mode_reg[energy_acc_pkg::ACM_B_SEL_LO +: 2]);
    case (b_sel)
      energy_acc_pkg::B_SEL_MEASURED: vb_sel = vb_ext;
      energy_acc_pkg::B_SEL_A_MINUS_C: vb_sel = va_ext - vc_ext;
      energy_acc_pkg::B_SEL_NEG_A_MINUS_C: vb_sel = -va_ext - vc_ext;
      energy_acc_pkg::B_SEL_NEG_A: vb_sel = -va_ext;
      default: vb_sel = vb_ext;
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_b_voltage_o <= '0;
    end else begin
      phase_b_voltage_o <= vb_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // First stage, one integrator per channel

  logic [energy_acc_pkg::THR_W-1:0] threshold;
  logic [CH-1:0][POWER_W-1:0] power_all;

  assign threshold = {thr_high_reg, thr_low_reg};
  assign power_all = {fund_power_i, total_power_i};

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_stage1
      stage1_accum #(
        .POWER_W(POWER_W),
        .THR_W(energy_acc_pkg::THR_W)
      ) u_stage1 (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .sample_en_i(sample_tick_o),
        .power_i(power_all[g]),
        .threshold_i(threshold),
        .pulse_o(energy_pulse_o[g]),
        .negative_o(phase_sign_o[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Line-cycle zero-crossing counter

  logic [15:0] zc_cnt_reg;
  logic [1:0] zc_hits;
  logic [16:0] zc_sum;
  logic period_end;
  logic line_done;
  logic [2:0] zc_sel;

  always_comb begin
    zc_sel = zero_cross_i & line_mode_reg[energy_acc_pkg::LCM_ZX_SEL_LO +: 3];
    zc_hits = 2'(zc_sel[0]) + 2'(zc_sel[1]) + 2'(zc_sel[2]);
    zc_sum = {1'b0, zc_cnt_reg} + 17'(zc_hits);
    period_end = half_cycles_reg != 16'h0000 && zc_hits != 2'b00
      && zc_sum >= {1'b0, half_cycles_reg};
    line_done = period_end && line_en && !half_cycles_wr;
  end

  // The counter runs even with line mode off; a half-cycle rewrite restarts it only while line mode is on.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      zc_cnt_reg <= '0;
    end else if (half_cycles_wr && line_en) begin
      zc_cnt_reg <= '0;
    end else if (period_end) begin
      zc_cnt_reg <= '0;
    end else begin
      zc_cnt_reg <= zc_sum[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second stage and watt-hour registers

  logic [WH_W-1:0] acc2_reg [CH];
  logic [WH_W-1:0] wh_reg [CH];
  logic [WH_W-1:0] acc2_next [CH];
  logic [WH_W-1:0] wh_next [CH];
  logic [WH_W-1:0] step [CH];
  logic [CH-1:0] rd_clear;
  logic [CH-1:0] half_full;
  logic [3:0] rd_index;

  assign rd_index = energy_index(req_i.addr);

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      if (!energy_pulse_o[i]) begin
        step[i] = '0;
      end else if (phase_sign_o[i]) begin
        step[i] = 32'hFFFFFFFF;
      end else begin
        step[i] = 32'h00000001;
      end
      // Read-with-reset is not offered in line mode.
      rd_clear[i] = req_i.rd && rd_index[3] && rd_index[2:0] == 3'(i)
        && read_clear_en && !line_en;
      acc2_next[i] = acc2_reg[i] + step[i];
      if (rd_clear[i]) begin
        acc2_next[i] = step[i];
      end
      wh_next[i] = wh_reg[i];
      if (!line_en) begin
        wh_next[i] = acc2_next[i];
      end else if (line_done) begin
        wh_next[i] = acc2_next[i];
      end
      half_full[i] = wh_next[i][energy_acc_pkg::HALF_FULL_BIT]
        ^ wh_reg[i][energy_acc_pkg::HALF_FULL_BIT];
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < CH; i++) begin
        acc2_reg[i] <= '0;
        wh_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < CH; i++) begin
        acc2_reg[i] <= (line_en && line_done) ? '0 : acc2_next[i];
        wh_reg[i] <= wh_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and interrupt

  logic [DW-1:0] status_reg;
  logic [DW-1:0] status_set;
  logic [DW-1:0] status_clr;
  logic [DW-1:0] status_next;

  always_comb begin
    status_set = '0;
    status_set[energy_acc_pkg::ST_TOTAL_HALF_FULL] = |half_full[2:0];
    status_set[energy_acc_pkg::ST_FUND_HALF_FULL] = |half_full[5:3];
    status_set[energy_acc_pkg::ST_LINE_DONE] = line_done;
    status_clr = '0;
    if (req_i.wr && req_i.addr == energy_acc_pkg::ADDR_STATUS) begin
      status_clr = req_i.wdata & energy_acc_pkg::STATUS_BITS;
    end
    // A new event wins over a clear in the same cycle.
    status_next = (status_reg & ~status_clr) | status_set;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      status_reg <= energy_acc_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_out_n_o <= 1'b1;
    end else begin
      irq_out_n_o <= ~|(status_next & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (req_i.rd) begin
      if (rd_index[3]) begin
        rdata_o <= wh_reg[rd_index[2:0]];
      end else begin
        case (req_i.addr)
          energy_acc_pkg::ADDR_THR_HIGH: rdata_o <= {8'h00, thr_high_reg};
          energy_acc_pkg::ADDR_THR_LOW: rdata_o <= {8'h00, thr_low_reg};
          energy_acc_pkg::ADDR_STATUS: rdata_o <= status_reg;
          energy_acc_pkg::ADDR_MASK: rdata_o <= mask_reg;
          energy_acc_pkg::ADDR_LINE_MODE: rdata_o <= line_mode_reg;
          energy_acc_pkg::ADDR_ACC_MODE: rdata_o <= acc_mode_reg;
          energy_acc_pkg::ADDR_HALF_CYCLES: rdata_o <= {16'h0000, half_cycles_reg};
          default: rdata_o <= '0;
        endcase
      end
    end
  end

endmodule : active_energy_accumulator

// *** core/energy_acc_pkg.sv ***
/*
  Shared constants and types for the active energy accumulator: register
  indices, field positions, reset values, sample timing and the register
  request carrier.
  Assumes a single 20 MHz clock domain and a host port in that domain.
*/
package energy_acc_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  localparam int POWER_W = 32;
  localparam int THR_W = 48;
  localparam int THR_PART_W = 24;
  localparam int WH_W = 32;
  localparam int VOLT_W = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CHANNELS = 6;
  localparam int HALF_FULL_BIT = 30;

  // Register indices on the host port.
  localparam logic [ADDR_W-1:0] ADDR_THR_HIGH = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_THR_LOW = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_ENERGY_BASE = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_LINE_MODE = 4'hA;
  localparam logic [ADDR_W-1:0] ADDR_ACC_MODE = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_HALF_CYCLES = 4'hC;

  // Status and mask bit positions.
  localparam int ST_TOTAL_HALF_FULL = 0;
  localparam int ST_FUND_HALF_FULL = 1;
  localparam int ST_LINE_DONE = 5;
  localparam logic [DATA_W-1:0] STATUS_BITS = 32'h00000023;

  // Line cycle mode fields.
  localparam int LCM_ENERGY_EN = 0;
  localparam int LCM_ZX_SEL_LO = 3;
  localparam int LCM_READ_CLEAR = 6;
  localparam logic [DATA_W-1:0] LINE_MODE_BITS = 32'h00000079;

  // Accumulation mode fields.
  localparam int ACM_SIGN_MODE_LO = 0;
  localparam int ACM_B_SEL_LO = 4;
  localparam logic [DATA_W-1:0] ACC_MODE_BITS = 32'h00000033;

  localparam logic [THR_PART_W-1:0] THR_PART_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] STATUS_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] LINE_MODE_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] ACC_MODE_RESET = 32'h00000000;
  localparam logic [15:0] HALF_CYCLES_RESET = 16'hFFFF;

  typedef enum logic [1:0] {
    B_SEL_MEASURED = 2'b00,
    B_SEL_A_MINUS_C = 2'b01,
    B_SEL_NEG_A_MINUS_C = 2'b10,
    B_SEL_NEG_A = 2'b11
  } phase_b_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage : energy_acc_pkg

// *** core/stage1_accum.sv ***
/*
  First-stage energy integrator for one channel: adds a signed power sample
  on each sample tick and emits a signed pulse each time the threshold is
  crossed.
  Assumes the sample tick and power word are in the mclk_i domain.
*/
`timescale 1ns/1ps
module stage1_accum #(
  parameter int POWER_W = 32,
  parameter int THR_W = 48
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sample_en_i,
  input wire logic [POWER_W-1:0] power_i,
  input wire logic [THR_W-1:0] threshold_i,
  output logic pulse_o,
  output logic negative_o
);

  // Two guard bits keep a full threshold plus one full sample from wrapping.
  localparam int ACC_W = THR_W + 2;

  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] thr_ext;

  always_comb begin
    sum = acc_reg + $signed({{(ACC_W-POWER_W){power_i[POWER_W-1]}}, power_i});
    thr_ext = $signed({2'b00, threshold_i});
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_reg <= '0;
      pulse_o <= 1'b0;
      negative_o <= 1'b0;
    end else if (sample_en_i) begin
      if (sum >= thr_ext) begin
        acc_reg <= sum - thr_ext;
        pulse_o <= 1'b1;
        negative_o <= 1'b0;
      end else if (sum <= -thr_ext) begin
        acc_reg <= sum + thr_ext;
        pulse_o <= 1'b1;
        negative_o <= 1'b1;
      end else begin
        acc_reg <= sum;
        pulse_o <= 1'b0;
      end
    end else begin
      pulse_o <= 1'b0;
    end
  end

endmodule : stage1_accum

// *** tb/active_energy_accumulator_properties.sv ***
/*
  Checker on the top ports of the active energy accumulator.
  Assumes it is bound to the design top and sees only its ports.
*/
`timescale 1ns/1ps
module active_energy_accumulator_properties (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire energy_acc_pkg::reg_req_t req_i,
  input wire logic [2:0] zero_cross_i,
  input wire logic [energy_acc_pkg::DATA_W-1:0] rdata_o,
  input wire logic irq_out_n_o,
  input wire logic sample_tick_o,
  input wire logic [energy_acc_pkg::CHANNELS-1:0] energy_pulse_o,
  input wire logic [energy_acc_pkg::CHANNELS-1:0] phase_sign_o,
  input wire logic [1:0] pulse_output_sign_mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  //////////////////////////////////////////////////////////////////////////////
  // The first tick after reset has no earlier tick to measure from, so it is skipped.
  logic [11:0] gap_reg;
  logic seen_reg;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_reg <= 12'h000;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= sample_tick_o ? 12'h000 : gap_reg + 12'h001;
      seen_reg <= seen_reg | sample_tick_o;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  a_tick_spacing: assert property (sample_tick_o && seen_reg |->
    gap_reg == energy_acc_pkg::SAMPLE_CYCLES - 1) else $error("sample tick spacing wrong");
  a_pulse_on_tick: assert property (energy_pulse_o != '0 |-> $past(sample_tick_o))
    else $error("energy pulse without a sample tick");
  a_pulse_single: assert property (energy_pulse_o != '0 |=> energy_pulse_o == '0)
    else $error("energy pulse longer than one cycle");
  a_sign_at_pulse: assert property (
    ((phase_sign_o ^ $past(phase_sign_o)) & ~energy_pulse_o) == '0)
    else $error("phase sign changed without a pulse");
  // A mask write reaches the pin a cycle after a status write, as the pin uses the stored mask.
  a_irq_release: assert property ($rose(irq_out_n_o) |->
    ($past(req_i.wr) && $past(req_i.addr) == energy_acc_pkg::ADDR_STATUS) ||
    ($past(req_i.wr, 2) && $past(req_i.addr, 2) == energy_acc_pkg::ADDR_MASK))
    else $error("interrupt released unasked");
  a_irq_raise: assert property ($fell(irq_out_n_o) |-> $past(energy_pulse_o) != '0 ||
    $past(zero_cross_i) != '0 || $past(req_i.wr) || $past(req_i.rd) ||
    ($past(req_i.wr, 2) && $past(req_i.addr, 2) == energy_acc_pkg::ADDR_MASK))
    else $error("interrupt raised without cause");
  a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o))
    else $error("read data changed without a read");
  a_thr_padding: assert property (req_i.rd &&
    (req_i.addr == energy_acc_pkg::ADDR_THR_HIGH || req_i.addr == energy_acc_pkg::ADDR_THR_LOW)
    |=> rdata_o[31:24] == 8'h00) else $error("threshold upper byte not zero");
  // The mode register and the output copy are two flops in series, so the copy lags the write by two cycles.
  a_sign_mode: assert property (req_i.wr && req_i.addr == energy_acc_pkg::ADDR_ACC_MODE
    |-> ##2 pulse_output_sign_mode_o == $past(req_i.wdata[1:0], 2))
    else $error("sign mode not copied");
endmodule : active_energy_accumulator_properties

bind active_energy_accumulator active_energy_accumulator_properties u_props (
  .mclk_i(mclk_i),
  .reset_i(reset_i),
  .req_i(req_i),
  .zero_cross_i(zero_cross_i),
  .rdata_o(rdata_o),
  .irq_out_n_o(irq_out_n_o),
  .sample_tick_o(sample_tick_o),
  .energy_pulse_o(energy_pulse_o),
  .phase_sign_o(phase_sign_o),
  .pulse_output_sign_mode_o(pulse_output_sign_mode_o)
);

// *** tb/test_active_energy_accumulator.sv ***
/*
  Self-checking bench for the active energy accumulator: register access,
  signed two-stage accumulation, half-full flags, read-clear, line mode and
  phase B selection.
  Assumes one 20 MHz clock shared by the host port and the power inputs.
*/
`timescale 1ns/1ps
module test_active_energy_accumulator;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  energy_acc_pkg::reg_req_t req_i = '0;
  logic [2:0][31:0] total_power_i = '0;
  logic [2:0][31:0] fund_power_i = '0;
  logic [23:0] volt_a_i = 24'h000100;
  logic [23:0] volt_b_i = 24'h000020;
  logic [23:0] volt_c_i = 24'h000003;
  logic [2:0] zero_cross_i = 3'h0;
  logic [31:0] rdata_o;
  logic irq_out_n_o;
  logic sample_tick_o;
  logic [5:0] energy_pulse_o;
  logic [5:0] phase_sign_o;
  logic [24:0] phase_b_voltage_o;
  logic [1:0] pulse_output_sign_mode_o;
  logic [31:0] word;
  logic [31:0] exp_wh [6] = '{32'h2, 32'hFFFFFFFE, 32'h0, 32'h4, 32'hFFFFFFFC, 32'h0};
  logic [31:0] exp_vb [4] = '{32'h20, 32'hFD, 32'h01FFFEFD, 32'h01FFFF00};
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 mclk_i = ~mclk_i;

  active_energy_accumulator u_dut (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .req_i(req_i),
    .total_power_i(total_power_i),
    .fund_power_i(fund_power_i),
    .volt_a_i(volt_a_i),
    .volt_b_i(volt_b_i),
    .volt_c_i(volt_c_i),
    .zero_cross_i(zero_cross_i),
    .rdata_o(rdata_o),
    .irq_out_n_o(irq_out_n_o),
    .sample_tick_o(sample_tick_o),
    .energy_pulse_o(energy_pulse_o),
    .phase_sign_o(phase_sign_o),
    .phase_b_voltage_o(phase_b_voltage_o),
    .pulse_output_sign_mode_o(pulse_output_sign_mode_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    @(posedge mclk_i);
    req_i <= '{1'b1, 1'b0, addr, data};
    @(posedge mclk_i);
    req_i <= '0;
  endtask : wr

  // Read data is taken one step after the edge so the registered answer has landed.
  task automatic rd(input logic [3:0] addr, output logic [31:0] data);
    @(posedge mclk_i);
    req_i <= '{1'b0, 1'b1, addr, 32'h00000000};
    @(posedge mclk_i);
    req_i <= '0;
    #1;
    data = rdata_o;
  endtask : rd

  task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    rd(addr, got);
    chk(got, exp);
  endtask : rd_chk

  task automatic wait_tick();
    int n;
    n = 0;
    while (sample_tick_o !== 1'b1 && n < 3000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk({31'h0, n < 3000}, 32'h1);
    @(posedge mclk_i);
    #1;
  endtask : wait_tick

  task automatic zx_pulse();
    @(posedge mclk_i);
    zero_cross_i <= 3'h1;
    @(posedge mclk_i);
    zero_cross_i <= 3'h0;
  endtask : zx_pulse

  // The run needs about 10100 cycles; the ceiling leaves room for slow handshakes.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error at %0t: run timed out", $time);
      results();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd_chk(4'(a), (a == 12) ? 32'h0000FFFF : 32'h00000000);
    end
    wr(energy_acc_pkg::ADDR_THR_HIGH, 32'hFF7FFFFF);
    wr(energy_acc_pkg::ADDR_THR_LOW, 32'hFFFFFFFF);
    rd_chk(energy_acc_pkg::ADDR_THR_HIGH, 32'h007FFFFF);
    rd_chk(energy_acc_pkg::ADDR_THR_LOW, 32'h00FFFFFF);
    wr(energy_acc_pkg::ADDR_THR_HIGH, 32'h00000000);
    wr(energy_acc_pkg::ADDR_THR_LOW, 32'h00000064);
    wr(energy_acc_pkg::ADDR_ENERGY_BASE, 32'h12345678);
    rd_chk(energy_acc_pkg::ADDR_ENERGY_BASE, 32'h00000000);
    wr(energy_acc_pkg::ADDR_MASK, 32'h00000001);
    total_power_i <= {32'h00000000, 32'hFFFFFFC4, 32'h0000003C};
    fund_power_i <= {32'h00000000, 32'hFFFFFF9C, 32'h00000064};
    repeat (4) wait_tick();
    @(posedge mclk_i);
    total_power_i <= '0;
    fund_power_i <= '0;
    chk({26'h0, phase_sign_o}, 32'h00000012);
    for (int i = 0; i < 6; i++) begin
      rd_chk(energy_acc_pkg::ADDR_ENERGY_BASE + 4'(i), exp_wh[i]);
    end
    rd_chk(energy_acc_pkg::ADDR_STATUS, 32'h00000003);
    chk({31'h0, irq_out_n_o}, 32'h0);
    wr(energy_acc_pkg::ADDR_STATUS, 32'h00000001);
    #1;
    chk({31'h0, irq_out_n_o}, 32'h1);
    rd_chk(energy_acc_pkg::ADDR_STATUS, 32'h00000002);
    wr(energy_acc_pkg::ADDR_STATUS, 32'h00000002);
    rd_chk(energy_acc_pkg::ADDR_STATUS, 32'h00000000);
    // Clearing a negative register flips bit 30, which also counts as a half-full event.
    wr(energy_acc_pkg::ADDR_LINE_MODE, 32'h00000040);
    rd_chk(energy_acc_pkg::ADDR_ENERGY_BASE, 32'h00000002);
    rd_chk(energy_acc_pkg::ADDR_ENERGY_BASE, 32'h00000000);
    rd_chk(energy_acc_pkg::ADDR_ENERGY_BASE + 4'h1, 32'hFFFFFFFE);
    rd_chk(energy_acc_pkg::ADDR_STATUS, 32'h00000001);
    wr(energy_acc_pkg::ADDR_LINE_MODE, 32'h00000000);
    wr(energy_acc_pkg::ADDR_STATUS, 32'h00000023);
    wr(energy_acc_pkg::ADDR_MASK, 32'h00000020);
    wr(energy_acc_pkg::ADDR_LINE_MODE, 32'h00000009);
    wr(energy_acc_pkg::ADDR_HALF_CYCLES, 32'h00000002);
    zx_pulse();
    wr(energy_acc_pkg::ADDR_HALF_CYCLES, 32'h00000002);
    zx_pulse();
    rd(energy_acc_pkg::ADDR_STATUS, word);
    chk(word & 32'h00000020, 32'h00000000);
    zx_pulse();
    rd(energy_acc_pkg::ADDR_STATUS, word);
    chk(word & 32'h00000020, 32'h00000020);
    chk({31'h0, irq_out_n_o}, 32'h0);
    wr(energy_acc_pkg::ADDR_STATUS, 32'h00000023);
    zx_pulse();
    zx_pulse();
    rd_chk(energy_acc_pkg::ADDR_ENERGY_BASE, 32'h00000000);
    rd_chk(energy_acc_pkg::ADDR_ENERGY_BASE + 4'h3, 32'h00000000);
    wr(energy_acc_pkg::ADDR_LINE_MODE, 32'h00000000);
    for (int k = 0; k < 4; k++) begin
      // The phase B setting only drives phase_b_voltage_o; it never feeds the pulse outputs, which are left unchecked here.
      wr(energy_acc_pkg::ADDR_ACC_MODE, {26'h0, 2'(k), 2'h0, 2'(k)});
      repeat (2) @(posedge mclk_i);
      #1;
      chk({7'h0, phase_b_voltage_o}, exp_vb[k]);
      chk({30'h0, pulse_output_sign_mode_o}, 32'(k));
    end
    results();
  end
endmodule : test_active_energy_accumulator
